/* File: include/ssc_pkg.sv */
// ssc_pkg: constants and types shared by both ends of the screen switch link.
// assumes: included once ahead of the interface and the two end modules.

package ssc_pkg;

  // ----------------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------------
  localparam int          SCR_W         = 16;          // one controller word, 4 bcd digits
  localparam int          DIGITS        = 4;           // bcd digits in a screen number
  localparam int          BIT_ENTRIES   = 8;           // default count of switch bits
  localparam int          PARENTS       = 4;           // default count of parent screens
  localparam int          CTRL_WORDS    = 4;           // control area length in words
  localparam int          CTRL_SCR_IDX  = 0;           // word of the area holding the number

  // ----------------------------------------------------------------------
  // screen numbers with fixed meaning (bcd)
  // ----------------------------------------------------------------------
  localparam logic [15:0] SCR_NONE      = 16'h0000;    // blank, clears the display
  localparam logic [15:0] SCR_HIST_OCC  = 16'h1997;    // history by occurrence
  localparam logic [15:0] SCR_HIST_FREQ = 16'h1998;    // history by frequency
  localparam logic [15:0] SCR_HOST      = 16'h1999;    // host connection screen

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_SCREEN    = 16'h0000;    // screen shown before first poll
  localparam logic [15:0] RST_SETWORD   = 16'h0000;    // controller setting word at reset

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef logic [SCR_W-1:0] ssc_scr_t;                 // one bcd screen number

  // kind of the screen on display
  typedef enum logic [1:0] {
    KIND_USER  = 2'h0,                                 // ordinary screen
    KIND_HOCC  = 2'h1,                                 // history, occurrence order
    KIND_HFREQ = 2'h2,                                 // history, frequency order
    KIND_HOST  = 2'h3                                  // host connection screen
  } ssc_kind_e;

  // terminal polling states (one-hot)
  typedef enum logic [2:0] {
    TS_REQ  = 3'h1,                                    // poll request out, waiting answer
    TS_EVAL = 3'h2,                                    // compare fresh sample with last
    TS_GAP  = 3'h4                                     // one idle cycle between polls
  } ssc_tstate_e;

  // controller write states (one-hot)
  typedef enum logic [2:0] {
    CS_IDLE  = 3'h1,                                   // waiting for a user request
    CS_CLEAR = 3'h2,                                   // zero written, number follows
    CS_WRITE = 3'h4                                    // number written this cycle
  } ssc_cstate_e;

endpackage

/* File: include/ssc_link_if.sv */
// ssc_link_if: the polled link between terminal and programmable controller.
// assumes: one clock mclk shared by both ends; testbench instantiates it.

`timescale 1ns/1ps
`default_nettype none

interface ssc_link_if #(
  parameter int NB = ssc_pkg::BIT_ENTRIES               // switch bits in the table
) (
  input wire logic mclk                                 // common clock
);

  // ----------------------------------------------------------------------
  // link signals
  // ----------------------------------------------------------------------
  logic                    pollReq;                     // terminal asks for fresh data
  logic                    pollAck;                     // controller answers, data valid
  logic [ssc_pkg::SCR_W-1:0] setWord;                   // screen switch setting word
  logic [NB-1:0]           allocBits;                   // allocated switch bits
  logic [ssc_pkg::SCR_W-1:0] curWord;                   // current screen word
  logic                    swStrobe;                    // screen switch strobe flag
  logic                    notifyAck;                   // controller has read the notify

  // terminal end
  modport term (
    input  mclk, pollAck, setWord, allocBits, notifyAck,
    output pollReq, curWord, swStrobe
  );

  // controller end
  modport ctrl (
    input  mclk, pollReq, curWord, swStrobe,
    output pollAck, setWord, allocBits, notifyAck
  );

endinterface

`default_nettype wire

/* File: design/ssc_controller.sv */
// ssc_controller: controller end, owns the setting word and the switch bits.
// assumes: ssc_pkg compiled first; link joined to a terminal by the testbench.

`timescale 1ns/1ps
`default_nettype none

module ssc_controller #(
  parameter int NB        = ssc_pkg::BIT_ENTRIES,       // switch bits in the table
  parameter bit COPY_BACK = 1'b1                        // copy current word back on strobe
) (
  input  wire logic                        mclk,        // clock, 200 mhz
  input  wire logic                        rst,         // async reset, active high
  input  wire logic                        ce,          // clock enable, freezes all state
  ssc_link_if.ctrl                         lnk,         // link to the terminal
  input  wire logic                        reqValid,    // one-cycle screen request
  input  wire logic [ssc_pkg::SCR_W-1:0]   reqScreen,   // wanted screen, bcd
  input  wire logic [NB-1:0]               bitsIn,      // levels for the switch bits
  output logic                             reqBusy,     // request in progress
  output logic [ssc_pkg::SCR_W-1:0]        seenScreen,  // last current word read
  output logic                             seenPulse    // strobe rising edge seen
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    ssc_pkg::ssc_cstate_e    st;                        // write sequence state
    logic [ssc_pkg::SCR_W-1:0] setw;                    // setting word
    logic [ssc_pkg::SCR_W-1:0] pend;                    // number after the clear
    logic [NB-1:0]           bits;                      // switch bit levels
    logic                    ack;                       // poll answer
    logic                    strobePrev;                // strobe of last cycle
    logic                    nack;                      // notify read
    logic [ssc_pkg::SCR_W-1:0] seen;                    // captured current word
    logic                    seenP;                     // edge pulse
    logic                    busy;                      // request in progress
  } ssc_ctrl_s;

  ssc_ctrl_s s_r;                                       // registered state
  ssc_ctrl_s s_nxt;                                     // next state

  // refuse a table width the bit vector cannot carry
  if (NB < 1 || NB > 64) begin : gNbRange
    $error("ssc_controller: NB out of range");
  end

  // next state
  always_comb begin
    s_nxt       = s_r;
    s_nxt.seenP = 1'b0;
    s_nxt.nack  = 1'b0;
    s_nxt.bits  = bitsIn;
    s_nxt.ack   = lnk.pollReq & ~s_r.ack;               // answer each poll once
    case (s_r.st)
      ssc_pkg::CS_IDLE: begin
        if (reqValid) begin
          if (reqScreen == s_r.setw) begin              // same number: zero first, see [RQ4]
            s_nxt.setw = ssc_pkg::SCR_NONE;
            s_nxt.pend = reqScreen;
            s_nxt.st   = ssc_pkg::CS_CLEAR;
          end else begin
            s_nxt.setw = reqScreen;                     // place number, see [RQ1]
            s_nxt.st   = ssc_pkg::CS_WRITE;
          end
        end
      end
      ssc_pkg::CS_CLEAR: begin
        if (s_r.ack) begin                              // zero seen by a poll first
          s_nxt.setw = s_r.pend;
          s_nxt.st   = ssc_pkg::CS_WRITE;
        end
      end
      ssc_pkg::CS_WRITE: begin
        s_nxt.st = ssc_pkg::CS_IDLE;
      end
      default: s_nxt.st = ssc_pkg::CS_IDLE;
    endcase
    // strobe rising edge: read current word, acknowledge
    s_nxt.strobePrev = lnk.swStrobe;
    if (lnk.swStrobe && !s_r.strobePrev) begin
      s_nxt.seen  = lnk.curWord;
      s_nxt.seenP = 1'b1;
      s_nxt.nack  = 1'b1;
      if (COPY_BACK && s_r.st == ssc_pkg::CS_IDLE && !reqValid) begin
        s_nxt.setw = lnk.curWord;                       // keep word consistent, see [RQ9]
      end
    end
    s_nxt.busy = (s_nxt.st != ssc_pkg::CS_IDLE);       // registered busy flag
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: ssc_pkg::CS_IDLE, setw: ssc_pkg::RST_SETWORD, default: '0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign lnk.pollAck   = s_r.ack;
  assign lnk.setWord   = s_r.setw;
  assign lnk.allocBits = s_r.bits;
  assign lnk.notifyAck = s_r.nack;
  assign reqBusy       = s_r.busy;
  assign seenScreen    = s_r.seen;
  assign seenPulse     = s_r.seenP;

endmodule

`default_nettype wire

/* File: design/ssc_terminal.sv */
// ssc_terminal: terminal end, polls the control area and the switch bits,
// picks the displayed screen and reports it in the notify area.
// assumes: ssc_pkg compiled first; controller answers every poll request.
//
// Operation
// [RQ1] controller writes wanted number into setting word
// [RQ2] screen numbers are four bcd digits
// [RQ3] switch only when setting word changes
// [RQ4] controller writes zero before repeating number
// [RQ5] power-up shows number found in setting word
// [RQ6] setting word switch updates current-screen word
// [RQ7] 1997, 1998, 1999 are special screens
// [RQ8] parent shows group, child shows alone
// [RQ9] controller copies current word on strobe edge
// [RQ10] bit rising edge shows its registered screen
// [RQ11] bit falling edge changes nothing
// [RQ12] all switch bits sampled whatever is shown
// [RQ13] strobe set with current-word update
// [RQ14] strobe cleared once notification delivered
// [RQ15] current word reports parent of group
// [RQ16] control area is four consecutive words
// [RQ17] poll repeatedly, compare with previous sample

`timescale 1ns/1ps
`default_nettype none

module ssc_terminal #(
  parameter int NB  = ssc_pkg::BIT_ENTRIES,             // switch bits in the table
  parameter int NP  = ssc_pkg::PARENTS                  // parent screens known
) (
  input  wire logic                          mclk,      // clock, 200 mhz
  input  wire logic                          rst,       // async reset, active high
  input  wire logic                          ce,        // clock enable, freezes all state
  ssc_link_if.term                           lnk,       // link to the controller
  input  wire logic [NB*ssc_pkg::SCR_W-1:0]  bitScreens, // screen registered per bit
  input  wire logic [NP*ssc_pkg::SCR_W-1:0]  parentNums, // numbers of parent screens
  output logic [ssc_pkg::SCR_W-1:0]          dispScreen, // screen on display
  output logic                               dispGroup,  // whole group shown
  output ssc_pkg::ssc_kind_e                 dispKind,   // kind of screen shown
  output logic                               dispBlank,  // display cleared
  output logic                               switchPulse // one cycle on each switch to a valid screen, none on a clear to zero
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (NB < 1 || NB > 64) begin : gNbRange
    $error("ssc_terminal: NB out of range");
  end
  if (NP < 1 || NP > 64) begin : gNpRange
    $error("ssc_terminal: NP out of range");
  end
  if (ssc_pkg::CTRL_SCR_IDX >= ssc_pkg::CTRL_WORDS) begin : gIdxRange
    $error("ssc_terminal: bad word index");
  end

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------

  // true when every nibble is a decimal digit
  function automatic logic bcdOk(input logic [ssc_pkg::SCR_W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < ssc_pkg::DIGITS; i++) begin
      if (v[i*4 +: 4] > 4'h9) ok = 1'b0;                // see [RQ2]
    end
    return ok;
  endfunction

  // true when the number names a parent screen
  function automatic logic isParent(input logic [ssc_pkg::SCR_W-1:0] v,
                                    input logic [NP*ssc_pkg::SCR_W-1:0] tbl);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (tbl[i*ssc_pkg::SCR_W +: ssc_pkg::SCR_W] == v) hit = 1'b1;
    end
    return hit;
  endfunction

  // kind of screen from its number
  function automatic ssc_pkg::ssc_kind_e kindOf(input logic [ssc_pkg::SCR_W-1:0] v);
    ssc_pkg::ssc_kind_e k;
    k = ssc_pkg::KIND_USER;
    if (v == ssc_pkg::SCR_HIST_OCC) begin               // see [RQ7]
      k = ssc_pkg::KIND_HOCC;
    end else if (v == ssc_pkg::SCR_HIST_FREQ) begin
      k = ssc_pkg::KIND_HFREQ;
    end else if (v == ssc_pkg::SCR_HOST) begin
      k = ssc_pkg::KIND_HOST;
    end
    return k;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    ssc_pkg::ssc_tstate_e      st;                      // polling state
    logic                      req;                     // poll request out
    logic                      first;                   // no sample taken yet
    logic [ssc_pkg::SCR_W-1:0] setSmp;                  // fresh setting word
    logic [NB-1:0]             bitSmp;                  // fresh switch bits
    logic [ssc_pkg::SCR_W-1:0] setPrev;                 // setting word last observed
    logic [NB-1:0]             bitPrev;                 // bits last observed
    logic [ssc_pkg::SCR_W-1:0] disp;                    // displayed screen
    logic                      grp;                     // group displayed
    ssc_pkg::ssc_kind_e        kind;                    // kind displayed
    logic                      blank;                   // display cleared
    logic [ssc_pkg::SCR_W-1:0] cur;                     // current screen word
    logic                      strobe;                  // switch strobe flag
    logic                      swP;                     // switch pulse
  } ssc_term_s;

  ssc_term_s s_r;                                       // registered state
  ssc_term_s s_nxt;                                     // next state

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic                      doSw;                    // a switch happens now
    logic [ssc_pkg::SCR_W-1:0] tgt;                     // screen to switch to
    logic [NB-1:0]             rise;                    // rising bits
    logic                      found;                   // a rising bit picked
    doSw  = 1'b0;
    tgt   = s_r.disp;
    rise  = '0;
    found = 1'b0;
    s_nxt = s_r;
    s_nxt.swP = 1'b0;

    // notify delivered: flag back to zero, see [RQ14]
    if (lnk.notifyAck) begin
      s_nxt.strobe = 1'b0;
    end

    case (s_r.st)
      // poll out, sample area and bits on the answer, see [RQ17]
      ssc_pkg::TS_REQ: begin
        s_nxt.req = 1'b1;
        if (s_r.req && lnk.pollAck) begin
          s_nxt.req    = 1'b0;
          s_nxt.setSmp = lnk.setWord;                   // screen word of the area, see [RQ16]
          s_nxt.bitSmp = lnk.allocBits;                 // every bit each poll, see [RQ12]
          s_nxt.st     = ssc_pkg::TS_EVAL;
        end
      end

      // compare with the previous sample
      ssc_pkg::TS_EVAL: begin
        rise = s_r.bitSmp & ~s_r.bitPrev;               // only 0 to 1 counts, see [RQ10] [RQ11]
        if (s_r.first) begin
          doSw = 1'b1;                                  // startup screen from word, see [RQ5]
          tgt  = s_r.setSmp;
          rise = '0;                                    // bits high at startup are not edges
        end else if (s_r.setSmp != s_r.setPrev) begin
          doSw = 1'b1;                                  // change only, see [RQ3]
          tgt  = s_r.setSmp;
        end else begin
          for (int i = NB - 1; i >= 0; i--) begin       // lowest index wins
            if (rise[i]) begin
              found = 1'b1;
              tgt   = bitScreens[i*ssc_pkg::SCR_W +: ssc_pkg::SCR_W];
            end
          end
          doSw = found;
        end
        s_nxt.setPrev = s_r.setSmp;
        s_nxt.bitPrev = s_r.bitSmp;
        s_nxt.first   = 1'b0;

        if (doSw && tgt == ssc_pkg::SCR_NONE) begin
          s_nxt.blank = 1'b1;                           // zero clears the screen, see [RQ4]
          s_nxt.disp  = ssc_pkg::SCR_NONE;
          s_nxt.grp   = 1'b0;
          s_nxt.kind  = ssc_pkg::KIND_USER;
        end else if (doSw && bcdOk(tgt)) begin
          s_nxt.blank  = 1'b0;
          s_nxt.disp   = tgt;
          s_nxt.grp    = isParent(tgt, parentNums);     // parent group or child alone, see [RQ8]
          s_nxt.kind   = kindOf(tgt);                   // see [RQ7]
          s_nxt.cur    = tgt;                           // parent number reported, see [RQ6] [RQ15]
          s_nxt.strobe = 1'b1;                          // set wins over clear, see [RQ13]
          s_nxt.swP    = 1'b1;
        end
        s_nxt.st = ssc_pkg::TS_GAP;
      end

      // one idle cycle, then poll again
      ssc_pkg::TS_GAP: begin
        s_nxt.st = ssc_pkg::TS_REQ;
      end

      default: begin
        s_nxt.st  = ssc_pkg::TS_REQ;
        s_nxt.req = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: ssc_pkg::TS_REQ, first: 1'b1, disp: ssc_pkg::RST_SCREEN,
               cur: ssc_pkg::RST_SCREEN, kind: ssc_pkg::KIND_USER, blank: 1'b1,
               default: '0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from the state register
  // ----------------------------------------------------------------------
  assign lnk.pollReq  = s_r.req;
  assign lnk.curWord  = s_r.cur;
  assign lnk.swStrobe = s_r.strobe;
  assign dispScreen   = s_r.disp;
  assign dispGroup    = s_r.grp;
  assign dispKind     = s_r.kind;
  assign dispBlank    = s_r.blank;
  assign switchPulse  = s_r.swP;

endmodule

`default_nettype wire

/* File: sim/ssc_link_chk.sv */
// ssc_link_chk: timing checks on the poll and notify link between the two ends.
// assumes: instantiated beside the link interface, every signal wired by name.

`timescale 1ns/1ps
`default_nettype none

module ssc_link_chk #(
  parameter int NB = ssc_pkg::BIT_ENTRIES     // switch bits in the table
) (
  input wire logic                    mclk,      // common clock
  input wire logic                    rst,       // async reset, active high
  input wire logic                    pollReq,   // terminal poll request
  input wire logic                    pollAck,   // controller poll answer
  input wire logic [ssc_pkg::SCR_W-1:0] setWord,  // setting word
  input wire logic [NB-1:0]           allocBits, // switch bit levels
  input wire logic [ssc_pkg::SCR_W-1:0] curWord,  // current screen word
  input wire logic                    swStrobe,  // switch strobe flag
  input wire logic                    notifyAck  // notify delivered
);
  // ----------------------------------------------------------------------
  // poll handshake
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_req_answered: assert property (pollReq && !pollAck |=> pollAck)
    else $error("poll request not answered next cycle");
  chk_req_held: assert property (pollReq && !pollAck |=> pollReq)
    else $error("poll request dropped before answer");
  chk_ack_cause: assert property (pollAck |-> $past(pollReq) && !$past(pollAck))
    else $error("poll answer without request");
  chk_poll_gap: assert property ($fell(pollReq) |-> !pollReq [*3] ##1 pollReq)
    else $error("poll spacing wrong");

  // ----------------------------------------------------------------------
  // notify area
  // ----------------------------------------------------------------------
  chk_strobe_with_cur: assert property ($changed(curWord) |-> swStrobe)
    else $error("current word changed without strobe");
  chk_strobe_clear: assert property ($rose(swStrobe) |-> ##1 notifyAck ##1 !swStrobe)
    else $error("strobe not cleared after notify");
  chk_ack_pulse: assert property (notifyAck |=> !notifyAck)
    else $error("notify answer longer than one cycle");
  chk_cur_bcd: assert property ($changed(curWord) |-> curWord != 16'h0000 &&
    curWord[3:0] <= 4'h9 && curWord[7:4] <= 4'h9 && curWord[11:8] <= 4'h9 &&
    curWord[15:12] <= 4'h9) else $error("current word not a valid screen number");

  cov_bit_rise: cover property ($rose(allocBits[0]));
endmodule

`default_nettype wire

/* File: sim/test_screen_switch_control.sv */
// test_screen_switch_control: both ends joined, user sides driven and compared.
// assumes: package, interface and both end modules compiled beforehand.

`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errorCnt++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module test_screen_switch_control;
  // ----------------------------------------------------------------------
  // signals and fixed tables
  // ----------------------------------------------------------------------
  localparam int NB = 4;                      // bench switch bits
  localparam int NP = 2;                      // bench parent screens
  localparam logic [NB*16-1:0] BSCR = {16'h0345, 16'h1997, 16'h0002, 16'h1000};
  localparam logic [NP*16-1:0] PARS = {16'h0100, 16'h0002};
  logic               mclk, rst, reqValid, reqBusy, seenPulse;
  logic               dispGroup, dispBlank, switchPulse;
  logic [15:0]        reqScreen, seenScreen, dispScreen;
  logic [NB-1:0]      bitsIn;                 // controller switch bit levels
  ssc_pkg::ssc_kind_e dispKind;               // shown screen kind
  int                 errorCnt, checked;
  logic [15:0]        q[$];                   // requested screens in order

  ssc_link_if #(.NB(NB)) ssc_link_if_i (.mclk(mclk));
  ssc_terminal #(.NB(NB), .NP(NP)) ssc_terminal_i (.mclk(mclk), .rst(rst), .ce(1'b1),
    .lnk(ssc_link_if_i), .bitScreens(BSCR), .parentNums(PARS), .dispScreen(dispScreen),
    .dispGroup(dispGroup), .dispKind(dispKind), .dispBlank(dispBlank),
    .switchPulse(switchPulse));
  ssc_controller #(.NB(NB)) ssc_controller_i (.mclk(mclk), .rst(rst), .ce(1'b1),
    .lnk(ssc_link_if_i), .reqValid(reqValid), .reqScreen(reqScreen), .bitsIn(bitsIn),
    .reqBusy(reqBusy), .seenScreen(seenScreen), .seenPulse(seenPulse));
  ssc_link_chk #(.NB(NB)) ssc_link_chk_i (.mclk(mclk), .rst(rst),
    .pollReq(ssc_link_if_i.pollReq), .pollAck(ssc_link_if_i.pollAck),
    .setWord(ssc_link_if_i.setWord), .allocBits(ssc_link_if_i.allocBits),
    .curWord(ssc_link_if_i.curWord), .swStrobe(ssc_link_if_i.swStrobe),
    .notifyAck(ssc_link_if_i.notifyAck));

  // ----------------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------------
  // kind of screen from its number
  function automatic ssc_pkg::ssc_kind_e kindOf(input logic [15:0] s);
    case (s)
      16'h1997: return ssc_pkg::KIND_HOCC;
      16'h1998: return ssc_pkg::KIND_HFREQ;
      16'h1999: return ssc_pkg::KIND_HOST;
      default:  return ssc_pkg::KIND_USER;
    endcase
  endfunction

  // parent screens show their group
  function automatic logic isParent(input logic [15:0] s);
    for (int i = 0; i < NP; i++) if (PARS[16*i+:16] == s) return 1'b1;
    return 1'b0;
  endfunction

  // random nonzero bcd number
  function automatic logic [15:0] rbcd();
    return {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 9 + 1)};
  endfunction

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  // wait a bounded span for a switch, compare whether one came
  task automatic waitSw(input bit want);
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(negedge mclk);
      seen = (switchPulse === 1'b1);
    end
    `CHK("switchPulse", want, seen)
    // strobe rise reaches the controller one cycle after the switch
    if (want) begin
      @(negedge mclk);
      `CHK("seenPulse", 1'b1, seenPulse)
    end
  endtask

  // one user request through the controller
  task automatic request(input logic [15:0] s, input bit want);
    reqValid = 1'b1;
    reqScreen = s;
    @(negedge mclk);
    reqValid = 1'b0;
    `CHK("reqBusy", 1'b1, reqBusy)
    waitSw(want);
  endtask

  // compare display and notify words, then let the link settle
  task automatic checkDisp(input logic [15:0] e);
    `CHK("dispScreen", e, dispScreen)
    `CHK("curWord", e, ssc_link_if_i.curWord)
    `CHK("dispKind", kindOf(e), dispKind)
    `CHK("dispGroup", isParent(e), dispGroup)
    `CHK("dispBlank", 1'b0, dispBlank)
    repeat (30) @(negedge mclk);
    `CHK("seenScreen", e, seenScreen)
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // cut a hang well beyond the expected thousand or so cycles
  initial begin
    #100000;
    errorCnt++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    reqScreen = 16'h0000;
    bitsIn = '0;
    errorCnt = 0;
    checked = 0;
    void'($urandom(32'h3e89));
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (10) @(negedge mclk);
    `CHK("dispBlank", 1'b1, dispBlank)
    q = '{16'h1997, 16'h1998, 16'h1999, 16'h0002, 16'h0100, 16'h0103};
    repeat (6) q.push_back(rbcd());
    foreach (q[i]) begin
      request(q[i], 1'b1);
      checkDisp(q[i]);
    end
    request(q[$], 1'b1);
    checkDisp(q[$]);
    request(16'h12a3, 1'b0);
    checkDisp(q[$]);
    request(16'h0000, 1'b0);
    `CHK("dispBlank", 1'b1, dispBlank)
    `CHK("curWord", q[$], ssc_link_if_i.curWord)
    for (int i = 0; i < NB; i++) begin
      bitsIn[i] = 1'b1;
      waitSw(1'b1);
      checkDisp(BSCR[16*i+:16]);
      bitsIn[i] = 1'b0;
      waitSw(1'b0);
      `CHK("dispScreen", BSCR[16*i+:16], dispScreen)
    end
    tally_and_finish();
  end
endmodule

`default_nettype wire
